/* verilog/gate_consts.svh */
// Constants for the flash suspend command gate
`ifndef GATE_CONSTS_SVH
`define GATE_CONSTS_SVH
// Notes on behaviour
// - Refused opcode does nothing, write latch unchanged
// - Busy, program and erase halt flags judge state
// - While busy accept only a short listed set
// - Program halted permits reads, resume, enables, etc
// - Program halted refuses program, erase, locks, power-down
// - Erase halted also permits buffer write, program
// - Erase halted programs only outside halted 64kB block
// - Erase halted still refuses erase, locks, power-down
// - Halt running operation within pause latency
// - Set paused state flag plus program or erase flag
// - Clear ready busy flag when pause completes
// - Pause opcode alone, eight bits, acted at release
// - Pause accepted regardless of write latch flag
// - Pause ignored during unpausable operations
`define OP_PAUSE_A 8'h75
`define OP_PAUSE_B 8'hb0
`define OP_RESUME_A 8'h7a
`define OP_RESUME_B 8'hd0
`define BLOCK_LSB 16
`define PAUSE_LATENCY_NS 20000
`define CLK_PERIOD_NS 4
`define BITS_PER_OP 3'h7
`endif

/* verilog/gate_pkg.sv */
// Types for the flash suspend command gate
package gate_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_PAUSING = 2'b10
  } run_state_t;
  typedef enum logic [1:0] {
    CL_OPEN = 2'b00,
    CL_PROG = 2'b01,
    CL_ERASE = 2'b10,
    CL_NEVER = 2'b11
  } op_class_t;
endpackage

/* verilog/opcode_sampler.sv */
// Link-side opcode shifter, capturing the first byte and flagging lone or mid-byte frames
`timescale 1ns/1ps
`default_nettype none
`include "gate_consts.svh"
module opcode_sampler (
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic [7:0] o_op,
  output logic o_eight,
  output logic o_odd
);
  logic [2:0] cnt_q; // Bits taken this frame
  logic [6:0] sh_q; // Partial opcode
  logic first_q; // Still inside first byte
  // Shift bits MSB first while selected
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_q <= 3'h0;
      sh_q <= 7'h00;
      first_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      sh_q <= {sh_q[5:0], i_si};
      if (cnt_q == `BITS_PER_OP) begin
        first_q <= 1'b0;
      end
    end
  end
  // Lone-byte flag, set on the eighth bit, cleared by a ninth bit or at deselect
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_eight <= 1'b0;
    end else if (cnt_q == `BITS_PER_OP && first_q) begin
      o_eight <= 1'b1; // Exactly one byte so far
    end else begin
      o_eight <= 1'b0; // Anything more is not a lone opcode
    end
  end
  // Capture the first byte
  always_ff @(posedge i_sck) begin
    if (cnt_q == `BITS_PER_OP && first_q) begin
      o_op <= {sh_q, i_si};
    end
  end
  // Off-boundary marker
  always_comb begin
    o_odd = (cnt_q != 3'h0);
  end
endmodule
`default_nettype wire

/* verilog/flash_suspend_command_gate.sv */
// Command permission gate and pause status for a serial flash
`timescale 1ns/1ps
`default_nettype none
`include "gate_consts.svh"
module flash_suspend_command_gate
  import gate_pkg::*;
#(
  parameter int unsigned PAUSE_LATENCY_CYC =
    (`PAUSE_LATENCY_NS) / (`CLK_PERIOD_NS),
  parameter int unsigned ADDR_W = 24
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sck, // Link clock
  input wire logic i_cs_n, // Link chip select, active low
  input wire logic i_si, // Link serial in
  input wire logic [7:0] i_cmd_op, // Decoded opcode from core
  input wire logic i_cmd_valid, // Core presents opcode, one pulse
  input wire logic [ADDR_W-1:0] i_cmd_addr, // Target address
  input wire logic i_op_start, // Embedded op starts, one pulse
  input wire logic i_op_is_erase, // Started op is an erase
  input wire logic i_op_pausable, // Started op may be paused
  input wire logic [ADDR_W-1:0] i_op_addr, // Started op address
  input wire logic i_op_done, // Embedded op finishes, one pulse
  input wire logic i_resume, // Resume performed, one pulse
  input wire logic i_halted, // Engine reports halted
  output logic o_cmd_allow, // Opcode may run
  output logic o_cmd_refuse, // Opcode discarded
  output logic o_halt_req, // Ask engine to halt
  output logic o_ready_busy_flag, // Status register 1 busy bit
  output logic o_paused_state_flag, // Status register 2 pause bit
  output logic o_program_halted_flag, // Status register 5
  output logic o_erase_halted_flag, // Status register 5
  output logic o_pause_timeout // Halt overran latency
);
  initial begin
    if (ADDR_W <= `BLOCK_LSB || PAUSE_LATENCY_CYC < 1) begin
      $error("flash_suspend_command_gate: bad parameters");
    end
  end

  localparam int unsigned CW = $clog2(PAUSE_LATENCY_CYC + 1);

  // Link-side capture
  logic [7:0] link_op; // Captured opcode
  logic link_eight; // Frame held exactly one byte
  logic link_odd; // Frame ended mid-byte
  opcode_sampler u_sampler (
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_si(i_si),
    .o_op(link_op),
    .o_eight(link_eight),
    .o_odd(link_odd)
  );

  // Pause request latched on chip-select rise, toggled per valid lone pause frame
  logic pause_tgl_q; // Link-domain toggle
  logic seen_q; // Frame saw at least one link clock
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end
  // Toggle at chip-select rise if frame was a valid lone pause opcode
  always_ff @(posedge i_cs_n or negedge i_nrst) begin
    if (!i_nrst) begin
      pause_tgl_q <= 1'b0;
    end else if (seen_q && link_eight && !link_odd &&
                 (link_op == `OP_PAUSE_A ||
                  link_op == `OP_PAUSE_B)) begin
      pause_tgl_q <= ~pause_tgl_q; // Act on release
    end
  end

  // Two-flop crossing of the toggle
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else begin
      tg_s1_q <= pause_tgl_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end
  logic pause_evt; // One-cycle pause request in core domain
  assign pause_evt = tg_s2_q ^ tg_s3_q;

  // Running operation bookkeeping
  run_state_t state_q; // Engine run state
  logic op_erase_q; // Running op is an erase
  logic op_pausable_q; // Running op may be paused
  logic [ADDR_W-1:`BLOCK_LSB] blk_q; // Block of halted erase
  logic [CW-1:0] lat_q; // Latency countdown

  // State machine for busy and pausing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (i_op_start) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (i_op_done) begin
            state_q <= ST_IDLE;
          end else if (pause_evt && op_pausable_q) begin
            state_q <= ST_PAUSING; // Independent of latch
          end
        end
        ST_PAUSING: begin
          if (i_halted || lat_q == '0) begin
            state_q <= ST_IDLE; // Halted, or latency countdown reached zero
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture attributes of the started operation
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      op_erase_q <= 1'b0;
      op_pausable_q <= 1'b0;
      blk_q <= '0;
    end else if (i_op_start && state_q == ST_IDLE) begin
      op_erase_q <= i_op_is_erase;
      op_pausable_q <= i_op_pausable; // Unpausable ops ignore
      if (i_op_is_erase && !o_program_halted_flag) begin
        blk_q <= i_op_addr[ADDR_W-1:`BLOCK_LSB];
      end
    end
  end

  // Latency countdown while pausing
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_q <= '0;
    end else if (state_q == ST_BUSY) begin
      lat_q <= CW'(PAUSE_LATENCY_CYC);
    end else if (state_q == ST_PAUSING && lat_q != '0) begin
      lat_q <= lat_q - 1'b1;
    end
  end

  logic pause_done; // Halt completes this cycle
  assign pause_done = (state_q == ST_PAUSING) &&
                      (i_halted || lat_q == '0);

  // Halt request to the engine
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_halt_req <= 1'b0;
      o_pause_timeout <= 1'b0;
    end else begin
      o_halt_req <= (state_q == ST_BUSY && pause_evt &&
                     op_pausable_q) ||
                    (state_q == ST_PAUSING && !pause_done);
      o_pause_timeout <= (state_q == ST_PAUSING) && !i_halted &&
                         (lat_q == '0);
    end
  end

  // Status flags
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready_busy_flag <= 1'b0;
      o_program_halted_flag <= 1'b0;
      o_erase_halted_flag <= 1'b0;
      o_paused_state_flag <= 1'b0;
    end else begin
      if (pause_done) begin
        o_ready_busy_flag <= 1'b0; // Ready again
        if (op_erase_q) begin
          o_erase_halted_flag <= 1'b1;
        end else begin
          o_program_halted_flag <= 1'b1;
        end
        o_paused_state_flag <= 1'b1;
      end else if (i_op_start || i_resume) begin
        o_ready_busy_flag <= 1'b1;
      end else if (i_op_done) begin
        o_ready_busy_flag <= 1'b0;
      end
      // Resume clears the program halt first, then erase
      if (i_resume && !pause_done) begin
        if (o_program_halted_flag) begin
          o_program_halted_flag <= 1'b0;
          o_paused_state_flag <= o_erase_halted_flag;
        end else begin
          o_erase_halted_flag <= 1'b0;
          o_paused_state_flag <= 1'b0;
        end
      end
    end
  end

  // Opcode classification
  op_class_t cls; // Restriction class of incoming opcode
  always_comb begin
    unique case (i_cmd_op)
      8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'hd4, 8'h06,
      8'h04, 8'h50, 8'h3c, 8'h3d, 8'h4b, 8'h5a, 8'h77, 8'hef,
      `OP_RESUME_A, `OP_RESUME_B:
        cls = CL_OPEN; // Allowed in both halted states
      8'h84, 8'h02, 8'ha2, 8'h32, 8'h88, 8'had, 8'haf:
        cls = CL_PROG; // Program type
      8'h05, 8'h35, 8'h15, 8'h65, 8'h25, 8'hf0, 8'h66, 8'h99,
      8'h9f, 8'h90, 8'h94, 8'hab, `OP_PAUSE_A, `OP_PAUSE_B:
        cls = CL_ERASE; // Busy-safe set, pause among them
      default:
        cls = CL_NEVER; // Erase, locks, writes, power-down
    endcase
  end

  // Permission decision
  logic same_blk; // Target in the halted erase block
  logic allow; // Combined permission
  assign same_blk = (i_cmd_addr[ADDR_W-1:`BLOCK_LSB] == blk_q);
  always_comb begin
    allow = 1'b1; // Idle passes everything
    if (o_ready_busy_flag) begin
      allow = (cls == CL_ERASE); // Busy list
    end else if (o_program_halted_flag) begin
      allow = (cls == CL_OPEN) || ((cls == CL_ERASE) &&
              i_cmd_op != `OP_PAUSE_A && i_cmd_op != `OP_PAUSE_B);
    end else if (o_erase_halted_flag) begin
      allow = (cls == CL_OPEN) || ((cls == CL_ERASE) &&
              i_cmd_op != `OP_PAUSE_A && i_cmd_op != `OP_PAUSE_B) ||
              ((cls == CL_PROG) && !same_blk);
    end
  end

  // Refused opcodes raise only the refuse strobe, nothing else
  assign o_cmd_allow = i_cmd_valid && allow;
  assign o_cmd_refuse = i_cmd_valid && !allow;

  // Checks
  busy_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_valid && o_ready_busy_flag && i_cmd_op == 8'h06)
      |-> o_cmd_refuse)
    else $error("write enable allowed while busy");
  prog_halt_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_valid && !o_ready_busy_flag && o_program_halted_flag &&
     i_cmd_op == 8'h02) |-> !o_cmd_allow)
    else $error("program allowed during program halt");
  erase_blk_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_valid && !o_ready_busy_flag && !o_program_halted_flag &&
     o_erase_halted_flag && i_cmd_op == 8'h02 && same_blk)
      |-> o_cmd_refuse)
    else $error("program into halted erase block");
  pause_lat_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_PAUSING) |-> (lat_q <= CW'(PAUSE_LATENCY_CYC)))
    else $error("pause latency counter out of range");
  pause_flags_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    pause_done |=> (o_paused_state_flag && !o_ready_busy_flag &&
     (o_erase_halted_flag || o_program_halted_flag)))
    else $error("pause completion flags wrong");
  idle_pass_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_valid && !o_ready_busy_flag && !o_program_halted_flag &&
     !o_erase_halted_flag) |-> o_cmd_allow)
    else $error("idle device refused opcode");
  nopause_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_BUSY && !op_pausable_q)
      |=> state_q != ST_PAUSING)
    else $error("unpausable operation paused");
  udpd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_cmd_valid && (o_ready_busy_flag || o_erase_halted_flag ||
     o_program_halted_flag) && i_cmd_op == 8'h79) |-> o_cmd_refuse)
    else $error("deep power-down allowed while active");
endmodule
`default_nettype wire

/* tb/spi_host_model.sv */
// Host model that shifts single opcode frames into the gate
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  // Link clock parked low, select high between frames
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b1;
  end
  // One frame of n bits, 48 ns link clock, data set while clock low
  task automatic frame(input logic [7:0] op, input int n);
    o_cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      o_si = op[7-i];
      #24 o_sck = 1'b1;
      #24 o_sck = 1'b0;
    end
    #20 o_cs_n = 1'b1;
    o_si = ~o_si; // Released line shows no stale bit
  endtask
endmodule
`default_nettype wire

/* tb/flash_suspend_command_gate_tb.sv */
// Self-checking bench for the flash suspend command gate
`timescale 1ns/1ps
`default_nettype none
module flash_suspend_command_gate_tb;
  logic i_clk, i_nrst, i_cmd_valid, i_op_start, i_op_is_erase;
  logic i_op_pausable, i_op_done, i_resume, i_halted, seen;
  logic [7:0] i_cmd_op;
  logic [23:0] i_cmd_addr, i_op_addr;
  wire sck, cs_n, si;
  logic allow, refuse, halt_req, busy, paused, ph, eh, tmo;
  int error_cnt, compares, cyc;
  // Every opcode of the permission table
  logic [7:0] codes [60] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7,
    8'hd4, 8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h84, 8'h02,
    8'ha2, 8'h32, 8'h88, 8'h58, 8'h0a, 8'had, 8'haf, 8'hb0, 8'h75, 8'hd0,
    8'h7a, 8'h06, 8'h04, 8'h50, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h3c, 8'h3d,
    8'h9b, 8'h4b, 8'h05, 8'h35, 8'h15, 8'h65, 8'h01, 8'h31, 8'h11, 8'h71,
    8'h6f, 8'h25, 8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hb9, 8'hab,
    8'h79, 8'h5a, 8'h77, 8'hef};
  spi_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
  flash_suspend_command_gate #(.PAUSE_LATENCY_CYC(20)) u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_cmd_op(i_cmd_op), .i_cmd_valid(i_cmd_valid),
    .i_cmd_addr(i_cmd_addr), .i_op_start(i_op_start),
    .i_op_is_erase(i_op_is_erase), .i_op_pausable(i_op_pausable),
    .i_op_addr(i_op_addr), .i_op_done(i_op_done), .i_resume(i_resume),
    .i_halted(i_halted), .o_cmd_allow(allow), .o_cmd_refuse(refuse),
    .o_halt_req(halt_req), .o_ready_busy_flag(busy),
    .o_paused_state_flag(paused), .o_program_halted_flag(ph),
    .o_erase_halted_flag(eh), .o_pause_timeout(tmo));
  // Core clock, 4 ns period
  always #2 i_clk = ~i_clk;
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  // Expected permission; st 0 idle, 1 busy, 2 program, 3 erase halted
  function automatic bit exp_ok(input logic [7:0] op, input int st);
    bit rd, nv, pg;
    rd = op inside {8'hb0, 8'h75, 8'h05, 8'h35, 8'h15, 8'h65, 8'h25,
      8'hf0, 8'h66, 8'h99, 8'h9f, 8'h90, 8'h94, 8'hab};
    nv = op inside {8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7,
      8'h58, 8'h0a, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h9b, 8'h01, 8'h31,
      8'h11, 8'h71, 8'h6f, 8'hb9, 8'h79, 8'hb0, 8'h75};
    pg = op inside {8'h84, 8'h02, 8'ha2, 8'h32, 8'h88, 8'had, 8'haf};
    case (st)
      0: return 1'b1;
      1: return rd;
      2: return !nv && !pg;
      default: return !nv;
    endcase
  endfunction
  // Counted compare
  task automatic check(input string name, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask
  // Present one opcode for a cycle and judge the verdict
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
    input logic e);
    @(negedge i_clk);
    i_cmd_op = op;
    i_cmd_addr = a;
    i_cmd_valid = 1'b1;
    #1;
    check("allow", e, allow);
    check("refuse", !e, refuse);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask
  // Whole table in one state
  task automatic sweep(input int st, input logic [23:0] a);
    foreach (codes[i]) cmd(codes[i], a, exp_ok(codes[i], st));
  endtask
  // One-cycle pulse
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask
  // Start an embedded operation
  task automatic start(input logic e, input logic p, input logic [23:0] a);
    i_op_is_erase = e;
    i_op_pausable = p;
    i_op_addr = a;
    pulse(i_op_start);
    @(negedge i_clk);
  endtask
  // Status flags
  task automatic flags(input logic b, s, p, e);
    check("busy", b, busy);
    check("paused", s, paused);
    check("prog_halted", p, ph);
    check("erase_halted", e, eh);
  endtask
  // Bounded wait for a halt request
  task automatic wait_halt(input logic e);
    for (int i = 0; i < 30 && halt_req !== 1'b1; i++) @(negedge i_clk);
    check("halt_req", e, halt_req);
  endtask
  // Verdict
  task automatic summarize();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    {i_clk, i_nrst, i_cmd_valid, i_op_start, i_op_is_erase} = '0;
    {i_op_pausable, i_op_done, i_resume, i_halted, seen} = '0;
    {i_cmd_op, i_cmd_addr, i_op_addr} = '0;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    flags(0, 0, 0, 0);
    sweep(0, 24'h000000);
    host.frame(8'h75, 8);
    wait_halt(0);
    start(0, 1, 24'h000100);
    flags(1, 0, 0, 0);
    sweep(1, 24'h000000);
    host.frame(8'hb0, 7);
    wait_halt(0);
    host.frame(8'hb0, 8);
    wait_halt(1);
    i_halted = 1'b1;
    repeat (3) @(negedge i_clk);
    flags(0, 1, 1, 0);
    check("halt_req", 0, halt_req);
    sweep(2, 24'h000000);
    host.frame(8'h75, 8);
    wait_halt(0);
    i_halted = 1'b0;
    pulse(i_resume);
    pulse(i_op_done);
    @(negedge i_clk);
    flags(0, 0, 0, 0);
    start(1, 1, 24'h010000);
    host.frame(8'h75, 8);
    wait_halt(1);
    repeat (30) begin
      @(negedge i_clk);
      seen = seen | tmo;
    end
    check("timeout", 1, seen);
    flags(0, 1, 0, 1);
    sweep(3, 24'h020000);
    cmd(8'h02, 24'h01ff00, 0);
    cmd(8'h88, 24'h000000, 1);
    pulse(i_resume);
    pulse(i_op_done);
    start(1, 0, 24'h000000);
    host.frame(8'hb0, 8);
    wait_halt(0);
    flags(1, 0, 0, 0);
    i_nrst = 1'b0;
    @(negedge i_clk);
    flags(0, 0, 0, 0);
    summarize();
  end
endmodule
`default_nettype wire
